//--- hdl/cgc_top.sv
// processor-domain idle and peripheral clock gating controller
// assumes a classic wishbone master and the core idle pulse on clk
//
// Register access over Wishbone was decided locally.
`timescale 1ns/100ps
// Notes on behaviour
// - idle copies configuration to status, gates clocks
// - bit 9 idles the accelerator
// - bit 8 idles the fetch port
// - bit 7 idles the memory port
// - bit 6 idles the io port
// - bit 5 idles the data port
// - bit 0 idles the core
// - status reports idle state, bits 4:1 zero
// - ports without full field: bus error, no change
// - fetch, io or data port bits without core bit: bus error
// - emulator attached ignores idle requests
// - gated peripherals keep their state
// - peripheral gating applies within six clocks
// - gate register: bit15 system_clock, bit5 reserved zero
// - gate bit one stops, zero runs
// - system_clock disable holds until wake pin high
module cgc_top
   import cgc_pkg::*;
(
   // clock and reset
   input  wire logic               clk,
   input  wire logic               rstn,
   // wishbone slave
   input  wire logic               wb_cyc_i,
   input  wire logic               wb_stb_i,
   input  wire logic               wb_we_i,
   input  wire logic [17:0]        wb_adr_i,
   input  wire logic [3:0]         wb_sel_i,
   input  wire logic [31:0]        wb_dat_i,
   output logic      [31:0]        wb_dat_o,
   output logic                    wb_ack_o,
   output logic                    wb_err_o,
   // core side
   input  wire cgc_pkg::cgc_core_s core_i,
   input  wire logic               wakeup_pin,
   output logic                    bus_error_flag,
   // gate outputs, one means stopped
   output cgc_pkg::cgc_gate_s      cpu_gate_o,
   output logic      [14:0]        periph_gate_o,
   output logic                    system_clock_stop
);
   import cgc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic [15:0] idle_configuration_r;
   logic [15:0] idle_status_r;
   logic [15:0] peripheral_gate_one_r;
   logic        system_clock_stopped_r;
   logic        err_seen_r;
   logic        emu_ignore_r;
   logic        bus_error_r;
   cgc_bus_e    bus_st_r;
   logic [31:0] rd_nxt;
   logic [15:0] adr_idx;
   logic        hit;
   logic        wr_go;
   logic        wr_lo;
   logic        wr_hi;
   logic        idle_bad;
   logic [15:0] gate_delayed;
   logic        idle_take;
   logic        wake_take;
   logic        err_clr;
   logic        sel_cfg;
   logic        sel_st;
   logic        sel_pg;
   logic        sel_evt;
   logic        sel_ctl;
   logic        bus_req;
   logic        bus_take;
   logic        wr_cfg;
   logic        wr_pg;
   logic        idle_reject;
   logic [15:0] idle_status_nxt;
   logic [15:0] pg_nxt;
   logic        system_clock_stop_nxt;

   // address decode, one select per register
   assign adr_idx = wb_adr_i[17:2];
   assign sel_cfg = (adr_idx == CGC_IDX_IDLE_CONFIGURATION);
   assign sel_st  = (adr_idx == CGC_IDX_IDLE_STATUS);
   assign sel_pg  = (adr_idx == CGC_IDX_PERIPHERAL_GATE_ONE);
   assign sel_evt = (adr_idx == CGC_IDX_EVENT_STATUS);
   assign sel_ctl = (adr_idx == CGC_IDX_CONTROL);
   assign hit     = sel_cfg || sel_st || sel_pg || sel_evt || sel_ctl;

   // a request is taken only while the handshake is idle
   assign bus_req  = wb_cyc_i && wb_stb_i;
   assign bus_take = (bus_st_r == CGC_ST_IDLE) && bus_req;
   assign wr_go    = bus_take && wb_we_i && hit;
   assign wr_cfg   = wr_go && sel_cfg;
   assign wr_pg    = wr_go && sel_pg;
   assign wr_lo = wb_sel_i[0];
   assign wr_hi = wb_sel_i[1];

   ////////////////////////////////////////////////////////////////////////////
   // bus handshake, one wait cycle then ack for one cycle
   always_ff @(posedge clk) begin
      if (!rstn) begin
         bus_st_r <= CGC_ST_IDLE;
      end else begin
         case (bus_st_r)
            CGC_ST_IDLE: begin
               if (bus_req) begin
                  bus_st_r <= CGC_ST_ACK;
               end
            end
            CGC_ST_ACK: begin
               bus_st_r <= CGC_ST_DONE;
            end
            CGC_ST_DONE: begin
               if (!bus_req) begin
                  bus_st_r <= CGC_ST_IDLE;
               end
            end
            default: begin
               bus_st_r <= CGC_ST_IDLE;
            end
         endcase
      end
   end

   // ack for a mapped index, one cycle
   always_ff @(posedge clk) begin
      if (!rstn) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_take && hit;
      end
   end

   // err for an unmapped index, one cycle
   always_ff @(posedge clk) begin
      if (!rstn) begin
         wb_err_o <= 1'b0;
      end else begin
         wb_err_o <= bus_take && !hit;
      end
   end

   // read data, held until the next access
   always_ff @(posedge clk) begin
      if (!rstn) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (bus_take) begin
         wb_dat_o <= hit ? rd_nxt : CGC_UNMAPPED_DATA;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux
   always_comb begin
      rd_nxt = 32'h0000_0000;
      case (adr_idx)
         CGC_IDX_IDLE_CONFIGURATION:  rd_nxt[15:0] = idle_configuration_r;
         CGC_IDX_IDLE_STATUS:         rd_nxt[15:0] = idle_status_r & CGC_STATUS_MASK;
         CGC_IDX_PERIPHERAL_GATE_ONE: rd_nxt[15:0] = peripheral_gate_one_r;
         CGC_IDX_EVENT_STATUS:        rd_nxt[1:0]  = {system_clock_stopped_r, err_seen_r};
         CGC_IDX_CONTROL:             rd_nxt[0]    = emu_ignore_r;
         default:                     rd_nxt = 32'h0000_0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // idle configuration register
   always_ff @(posedge clk) begin
      if (!rstn) begin
         idle_configuration_r <= CGC_RST_IDLE_CONFIGURATION;
      end else if (wr_cfg) begin
         if (wr_lo) begin
            idle_configuration_r[7:0] <= wb_dat_i[7:0];
         end
         if (wr_hi) begin
            idle_configuration_r[15:8] <= wb_dat_i[15:8] & CGC_IDLE_WR_MASK[15:8];
         end
      end
   end

   // emulator override enable, software may turn it off
   always_ff @(posedge clk) begin
      if (!rstn) begin
         emu_ignore_r <= 1'b1;
      end else if (wr_go && wr_lo && (adr_idx == CGC_IDX_CONTROL)) begin
         emu_ignore_r <= wb_dat_i[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // idle instruction handling
   cgc_idle_check u_check (
      .cfg (idle_configuration_r),
      .bad (idle_bad)
   );

   assign idle_take = core_i.req && !(core_i.emu_attached && emu_ignore_r);
   assign wake_take = core_i.wake_irq && idle_status_r[CGC_BIT_CORE];

   assign idle_reject = idle_take && idle_bad;

   always_comb begin
      idle_status_nxt = idle_status_r;
      if (idle_take && !idle_bad) begin
         idle_status_nxt = idle_configuration_r & CGC_STATUS_MASK;
      end else if (wake_take) begin
         idle_status_nxt = idle_status_r & ~CGC_WAKE_CLR_MASK;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         idle_status_r <= CGC_RST_IDLE_STATUS;
      end else begin
         idle_status_r <= idle_status_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         bus_error_r <= 1'b0;
      end else begin
         bus_error_r <= idle_reject;
      end
   end

   // sticky copy, set wins over write-one clear
   assign err_clr = wr_go && wr_lo && (adr_idx == CGC_IDX_EVENT_STATUS) && wb_dat_i[0];
   always_ff @(posedge clk) begin
      if (!rstn) begin
         err_seen_r <= 1'b0;
      end else if (idle_reject) begin
         err_seen_r <= 1'b1;
      end else if (err_clr) begin
         err_seen_r <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         cpu_gate_o <= '0;
      end else begin
         cpu_gate_o.accel      <= idle_status_r[CGC_BIT_ACCEL];
         cpu_gate_o.fetch_port <= idle_status_r[CGC_BIT_FETCH];
         cpu_gate_o.mem_port   <= idle_status_r[CGC_BIT_MEM];
         cpu_gate_o.io_port    <= idle_status_r[CGC_BIT_IO];
         cpu_gate_o.data_port  <= idle_status_r[CGC_BIT_DATA];
         cpu_gate_o.core       <= idle_status_r[CGC_BIT_CORE];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // peripheral gate one register
   always_comb begin
      pg_nxt = peripheral_gate_one_r;
      if (wr_pg) begin
         if (wr_lo) begin
            pg_nxt[7:0] = wb_dat_i[7:0] & CGC_PG_WR_MASK[7:0];
         end
         if (wr_hi) begin
            pg_nxt[15:8] = wb_dat_i[15:8];
         end
      end
      pg_nxt[CGC_BIT_PG_RSVD] = 1'b0;
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         peripheral_gate_one_r <= CGC_RST_PERIPHERAL_GATE_ONE;
      end else begin
         peripheral_gate_one_r <= pg_nxt;
      end
   end

   cgc_delay #(
      .WIDTH (16),
      .DEPTH (CGC_PG_PIPE)
   ) u_pg_delay (
      .clk  (clk),
      .rstn (rstn),
      .d    (peripheral_gate_one_r),
      .q    (gate_delayed)
   );

   // one stops the clock, state kept
   always_ff @(posedge clk) begin
      if (!rstn) begin
         periph_gate_o <= 15'h0000;
      end else begin
         periph_gate_o <= gate_delayed[14:0];
      end
   end

   // system clock stop while wake pin low
   assign system_clock_stop_nxt = gate_delayed[CGC_BIT_SYSTEM_CLOCK_DIS] && !wakeup_pin;

   // status copy for software
   always_ff @(posedge clk) begin
      if (!rstn) begin
         system_clock_stopped_r <= 1'b0;
      end else begin
         system_clock_stopped_r <= system_clock_stop_nxt;
      end
   end

   // pin toward the clock generator
   always_ff @(posedge clk) begin
      if (!rstn) begin
         system_clock_stop <= 1'b0;
      end else begin
         system_clock_stop <= system_clock_stop_nxt;
      end
   end

   assign bus_error_flag = bus_error_r;
endmodule

//--- hdl/cgc_pkg.sv
// package for the processor and peripheral clock gating controller
// assumes a 32-bit classic wishbone register bus on the system clock
package cgc_pkg;

   // register indexes, byte address is four times the index
   localparam logic [15:0] CGC_IDX_IDLE_CONFIGURATION  = 16'h0001;
   localparam logic [15:0] CGC_IDX_IDLE_STATUS         = 16'h0002;
   localparam logic [15:0] CGC_IDX_PERIPHERAL_GATE_ONE = 16'h1c02;
   localparam logic [15:0] CGC_IDX_EVENT_STATUS        = 16'h1c40;
   localparam logic [15:0] CGC_IDX_CONTROL             = 16'h1c41;

   // reset values
   localparam logic [15:0] CGC_RST_IDLE_CONFIGURATION  = 16'h0000;
   localparam logic [15:0] CGC_RST_IDLE_STATUS         = 16'h0000;
   localparam logic [15:0] CGC_RST_PERIPHERAL_GATE_ONE = 16'h0000;

   // idle configuration field positions
   localparam int CGC_BIT_ACCEL = 9;
   localparam int CGC_BIT_FETCH = 8;
   localparam int CGC_BIT_MEM   = 7;
   localparam int CGC_BIT_IO    = 6;
   localparam int CGC_BIT_DATA  = 5;
   localparam int CGC_CFG_HI    = 4;
   localparam int CGC_CFG_LO    = 1;
   localparam int CGC_BIT_CORE  = 0;
   localparam logic [3:0]  CGC_CFG_FULL       = 4'hf;
   localparam logic [15:0] CGC_IDLE_WR_MASK   = 16'h03ff;
   localparam logic [15:0] CGC_STATUS_MASK    = 16'h03e1;
   localparam logic [15:0] CGC_WAKE_CLR_MASK  = 16'h01e1;

   // peripheral gate one field positions
   localparam int CGC_BIT_SYSTEM_CLOCK_DIS = 15;
   localparam int CGC_BIT_PG_RSVD    = 5;
   localparam logic [15:0] CGC_PG_WR_MASK = 16'hffdf;

   // gating takes effect within this many system clocks
   localparam int CGC_PG_DELAY_CYC = 6;
   localparam int CGC_PG_PIPE      = 3;

   // bus answer codes
   localparam logic [31:0] CGC_UNMAPPED_DATA = 32'h0000_0000;

   // idle instruction request, wake interrupt and emulator attached flag from the core
   typedef struct packed {
      logic        req;
      logic        wake_irq;
      logic        emu_attached;
   } cgc_core_s;

   // gate outputs of the processor domain
   typedef struct packed {
      logic        accel;
      logic        fetch_port;
      logic        mem_port;
      logic        io_port;
      logic        data_port;
      logic        core;
   } cgc_gate_s;

   typedef enum logic [2:0] {
      CGC_ST_IDLE = 3'b001,
      CGC_ST_ACK  = 3'b010,
      CGC_ST_DONE = 3'b100
   } cgc_bus_e;

endpackage

//--- hdl/cgc_delay.sv
// fixed-latency pipeline for one control vector
// assumes a single clock and synchronous active low reset
`timescale 1ns/100ps
module cgc_delay #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 3
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rstn,
   // data
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] stage_r [DEPTH];

   always_ff @(posedge clk) begin
      if (!rstn) begin
         for (int i = 0; i < DEPTH; i++) begin
            stage_r[i] <= '0;
         end
      end else begin
         stage_r[0] <= d;
         for (int i = 1; i < DEPTH; i++) begin
            stage_r[i] <= stage_r[i-1];
         end
      end
   end

   assign q = stage_r[DEPTH-1];
endmodule

//--- hdl/cgc_idle_check.sv
// checks an idle request against the allowed combinations
// assumes the configuration word is stable during the idle instruction
`timescale 1ns/100ps
module cgc_idle_check (
   // configuration in
   input  wire logic [15:0] cfg,
   // verdict
   output logic             bad
);
   import cgc_pkg::*;
   logic any_port;
   logic core_port;

   assign any_port  = cfg[CGC_BIT_FETCH] | cfg[CGC_BIT_MEM] | cfg[CGC_BIT_IO]
                    | cfg[CGC_BIT_DATA];
   assign core_port = cfg[CGC_BIT_FETCH] | cfg[CGC_BIT_IO] | cfg[CGC_BIT_DATA];
   assign bad = (any_port && (cfg[CGC_CFG_HI:CGC_CFG_LO] != CGC_CFG_FULL))
              || (core_port && !cfg[CGC_BIT_CORE]);
endmodule

//--- bench/cgc_top_sva.sv
// checker for the clock gating controller
// sees only the top ports, bound after the module
`timescale 1ns/100ps
module cgc_top_sva
   import cgc_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        rstn,
   // wishbone
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [17:0] wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        wb_err_o,
   // core and gates
   input wire cgc_core_s   core_i,
   input wire logic        wakeup_pin,
   input wire logic        bus_error_flag,
   input wire cgc_gate_s   cpu_gate_o,
   input wire logic [14:0] periph_gate_o,
   input wire logic        system_clock_stop
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence req_s;
      $rose(wb_cyc_i && wb_stb_i);
   endsequence
   sequence quiet_s;
      (!core_i.req && !core_i.wake_irq)[*3];
   endsequence
   //////////////////////////////////////////////////////////////
   bus_answer_a: assert property (req_s |=> (wb_ack_o || wb_err_o))
      else $error("bus request not answered");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
      else $error("upper read data not zero");
   error_cause_a: assert property (bus_error_flag |-> $past(core_i.req))
      else $error("bus error without idle request");
   error_pulse_a: assert property (bus_error_flag |=> !bus_error_flag)
      else $error("bus error longer than one cycle");
   gates_hold_a: assert property (quiet_s |-> $stable(cpu_gate_o))
      else $error("gates changed without idle or wake");
   core_gate_a: assert property ($rose(cpu_gate_o.core) |-> $past(core_i.req, 2))
      else $error("core stopped without idle request");
   reserved_zero_a: assert property (periph_gate_o[5] == 1'b0)
      else $error("reserved gate bit set");
   gate_hold_a: assert property ((!wb_cyc_i)[*6] |-> $stable(periph_gate_o))
      else $error("peripheral gates changed without write");
   system_clock_wake_a: assert property (wakeup_pin[*6] |-> !system_clock_stop)
      else $error("system clock stopped with wake pin high");
endmodule
bind cgc_top cgc_top_sva chk (.*);

//--- bench/cgc_core_model.sv
// model of the core issuing idle instructions and wake interrupts
// assumes the bench calls its tasks just after a rising edge
`timescale 1ns/100ps
module cgc_core_model
   import cgc_pkg::*;
(
   // clock
   input  wire logic clk,
   // core side
   output cgc_core_s core_o,
   input  wire logic bus_error_flag_i
);
   initial core_o = '0;
   task automatic emu(input logic on);
      core_o.emu_attached <= on;
      @(posedge clk);
   endtask
   task automatic idle_instr(output logic be);
      repeat (6) @(posedge clk);
      core_o.req <= 1'b1;
      @(posedge clk);
      core_o.req <= 1'b0;
      @(posedge clk);
      be = bus_error_flag_i;
      @(posedge clk);
   endtask
   task automatic wake;
      core_o.wake_irq <= 1'b1;
      @(posedge clk);
      core_o.wake_irq <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
endmodule

//--- bench/testbench.sv
// self-checking bench for the clock gating controller
// drives wishbone and the core model, checks the ports
`timescale 1ns/100ps
module testbench;
   import cgc_pkg::*;
   localparam logic [15:0] CF = CGC_IDX_IDLE_CONFIGURATION;
   localparam logic [15:0] ST = CGC_IDX_IDLE_STATUS;
   localparam logic [15:0] PG = CGC_IDX_PERIPHERAL_GATE_ONE;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [17:0] wb_adr_i = '0;
   logic [3:0]  wb_sel_i = '0;
   logic [31:0] wb_dat_i = '0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        wb_err_o;
   logic        bus_error_flag;
   logic        system_clock_stop;
   logic        wakeup_pin = 1'b0;
   cgc_core_s   core_i;
   cgc_gate_s   cpu_gate_o;
   logic [14:0] periph_gate_o;
   logic        be;
   logic [15:0] q;
   int          err_count = 0;
   int          check_count = 0;
   always #2.5 clk = ~clk;
   cgc_top dut (.*);
   cgc_core_model pm (.clk(clk), .core_o(core_i), .bus_error_flag_i(bus_error_flag));
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      check_count++;
      if (g !== x) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, x, g);
      end
   endtask
   task automatic bus(input logic w, input logic [15:0] i, input logic [15:0] d);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= {i, 2'b00};
      wb_sel_i <= 4'h3;
      wb_dat_i <= {16'h0000, d};
      do begin
         @(posedge clk);
         n++;
      end while (!(wb_ack_o || wb_err_o) && n < 50);
      if (n == 50) chk("bus answer", 32'h0000_0001, 32'h0000_0000);
      q = wb_dat_o[15:0];
      be = wb_err_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [15:0] i, input logic [15:0] x);
      bus(1'b0, i, 16'h0000);
      chk($sformatf("reg %h", i), {16'h0000, x}, {16'h0000, q});
   endtask
   task automatic gates(input logic [5:0] x);
      chk("cpu gates", {26'h0, x}, {26'h0, cpu_gate_o});
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   //////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      rd(CF, CGC_RST_IDLE_CONFIGURATION);
      rd(ST, CGC_RST_IDLE_STATUS);
      rd(PG, CGC_RST_PERIPHERAL_GATE_ONE);
      bus(1'b1, CF, 16'hffff);
      rd(CF, 16'h03ff);
      pm.idle_instr(be);
      chk("good idle error", 32'h0, {31'h0, be});
      rd(ST, 16'h03e1);
      gates(6'h3f);
      pm.wake();
      gates(6'h20);
      rd(ST, 16'h0200);
      bus(1'b1, CF, 16'h0081);
      pm.idle_instr(be);
      chk("field error", 32'h1, {31'h0, be});
      bus(1'b1, CF, 16'h003e);
      pm.idle_instr(be);
      chk("core error", 32'h1, {31'h0, be});
      rd(ST, 16'h0200);
      gates(6'h20);
      bus(1'b1, PG, 16'hffff);
      rd(PG, 16'hffdf);
      repeat (6) @(posedge clk);
      chk("periph gates", 32'h7fdf, {17'h0, periph_gate_o});
      chk("clock stop", 32'h1, {31'h0, system_clock_stop});
      wakeup_pin <= 1'b1;
      repeat (6) @(posedge clk);
      chk("clock wake", 32'h0, {31'h0, system_clock_stop});
      bus(1'b1, PG, 16'h0000);
      repeat (6) @(posedge clk);
      chk("periph run", 32'h0, {17'h0, periph_gate_o});
      bus(1'b0, 16'h0003, 16'h0000);
      chk("unmapped", 32'h1, {31'h0, be});
      rd(CGC_IDX_CONTROL, 16'h0001);
      rd(CGC_IDX_EVENT_STATUS, 16'h0001);
      bus(1'b1, CGC_IDX_EVENT_STATUS, 16'h0001);
      rd(CGC_IDX_EVENT_STATUS, 16'h0000);
      pm.emu(1'b1);
      bus(1'b1, CF, 16'h0001);
      pm.idle_instr(be);
      chk("emu idle error", 32'h0, {31'h0, be});
      rd(ST, 16'h0200);
      bus(1'b1, CGC_IDX_CONTROL, 16'h0000);
      pm.idle_instr(be);
      rd(ST, 16'h0001);
      gates(6'h01);
      pm.wake();
      gates(6'h00);
      pm.emu(1'b0);
      test_done;
   end
   initial begin
      repeat (5000) @(posedge clk);
      err_count++;
      test_done;
   end
endmodule
